/* File: wra_adc_model.sv */
// behavioural a/d converter feeding conversion results to the averager
`timescale 1ns/1ps
`default_nettype none
module wra_adc_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [23:0] value,
  input wire logic [3:0] lag,
  output var wra_pkg::wra_sample_t conv,
  output logic busy
);
  import wra_pkg::*;
  logic pend_q;
  logic [3:0] wait_q;
  logic [5:0] hold_q;
  logic [23:0] val_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      conv <= '0;
      pend_q <= 1'b0;
      wait_q <= 4'h0;
      hold_q <= 6'h00;
      val_q <= 24'h000000;
    end else begin
      conv.valid <= 1'b0;
      // data means nothing outside the pulse, so keep it moving
      conv.data <= ~conv.data;
      if (hold_q != 6'h00) hold_q <= hold_q - 6'h01;
      if (start && !busy) begin
        pend_q <= 1'b1;
        wait_q <= lag;
        val_q <= value;
      end else if (pend_q) begin
        if (wait_q != 4'h0) begin
          wait_q <= wait_q - 4'h1;
        end else begin
          pend_q <= 1'b0;
          conv.valid <= 1'b1;
          conv.data <= val_q;
          // quiet spell covers the averager's 35-cycle spacing
          hold_q <= 6'h28;
        end
      end
    end
  end
  assign busy = pend_q | (hold_q != 6'h00);
endmodule
`default_nettype wire

/* File: wra_avg_div.sv */
// sequential signed divide of the stack sum by the entry count
`timescale 1ns/1ps
`default_nettype none
module wra_avg_div (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic signed [31:0] dividend,
  input wire logic [6:0] divisor,
  output logic busy,
  output logic done,
  output logic [23:0] quotient
);
  import wra_pkg::*;

  typedef struct packed {
    logic busy;
    logic [4:0] step;
    logic [6:0] rem;
    logic [31:0] quo;
    logic [6:0] den;
    logic neg;
    logic done;
    logic [23:0] q;
  } wra_div_st_t;

  wra_div_st_t s_q, s_d;
  logic [7:0] trial;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    trial = {s_q.rem, s_q.quo[31]};
    if (!s_q.busy && start) begin
      s_d.busy = 1'b1;
      s_d.step = '0;
      s_d.rem = '0;
      s_d.quo = dividend[31] ? 32'(-dividend) : dividend;
      s_d.den = divisor;
      s_d.neg = dividend[31];
    end else if (s_q.busy) begin
      // restoring division, one quotient bit a cycle
      s_d.quo = {s_q.quo[30:0], 1'b0};
      if (trial >= {1'b0, s_q.den}) begin
        s_d.rem = 7'(trial - {1'b0, s_q.den});
        s_d.quo[0] = 1'b1;
      end else begin
        s_d.rem = trial[6:0];
      end
      s_d.step = 5'(s_q.step + 5'h01);
      if (s_q.step == 5'(DIV_STEPS - 1)) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        // truncates toward zero for negative sums
        s_d.q = s_q.neg ? 24'(-s_d.quo[23:0]) : s_d.quo[23:0]; // [RULE_19]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;
  assign quotient = s_q.q;

  chk_div_latency: assert property (@(posedge clk) disable iff (reset) // [RULE_19]
    (start && !busy) |-> ##33 done)
    else $error("divide result not ready after 33 cycles");
  chk_div_busy: assert property (@(posedge clk) disable iff (reset) // [RULE_19]
    (start && !busy) |=> busy [*8])
    else $error("divider not busy after start");
endmodule
`default_nettype wire

/* File: wra_band.sv */
// window half-width: percentage (hundredths) applied to the full-scale value
`timescale 1ns/1ps
`default_nettype none
module wra_band (
  input wire logic clk,
  input wire logic reset,
  input wire logic [23:0] fscale,
  input wire logic [9:0] win,
  output logic [23:0] band
);
  import wra_pkg::*;

  typedef struct packed {
    logic [23:0] band;
  } wra_band_st_t;

  wra_band_st_t s_q, s_d;
  logic [33:0] prod;

  always_comb begin
    prod = fscale * win;
    s_d = s_q;
    s_d.band = 24'(prod / 34'(WIN_DIV)); // [RULE_09] [RULE_10]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign band = s_q.band;

  chk_band_bound: assert property (@(posedge clk) disable iff (reset) // [RULE_09]
    ##1 ($past(win) <= WIN_MAX_V) |-> band <= $past(fscale))
    else $error("window band exceeds full scale");
endmodule
`default_nettype wire

/* File: wra_pkg.sv */
// shared constants and types for the windowed reading averager
package wra_pkg;
  localparam int DATA_W = 24;
  localparam int SUM_W = 32;
  localparam int CNT_MAX = 100;
  localparam int N_FUNC = 7;
  localparam int DIV_STEPS = 32;
  localparam int WIN_DIV = 10000;
  localparam logic [6:0] CNT_MIN_V = 7'h01;
  localparam logic [6:0] CNT_MAX_V = 7'h64;
  localparam logic [9:0] WIN_MAX_V = 10'h3e8;
  localparam logic [2:0] FUNC_LAST = 3'h6;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FSCALE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0c;
  localparam logic [7:0] ADDR_CFG_BASE = 8'h20;
  localparam logic [7:0] ADDR_CFG_MASK = 8'he0;
  // field positions
  localparam int CTRL_FUNC_LSB = 0;
  localparam int CTRL_SCAN_BIT = 3;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_MOVING_BIT = 1;
  localparam int CFG_WIN_LSB = 2;
  localparam int CFG_CNT_LSB = 16;
  localparam int STATUS_SETTLING_BIT = 0;
  localparam int STATUS_SETTLED_BIT = 8;
  localparam int STATUS_FILL_LSB = 16;
  // reset values
  localparam logic [23:0] FSCALE_RST = 24'h0f4240;
  localparam logic [9:0] WIN_RST = 10'h00a;
  localparam logic [6:0] CNT_RST = 7'h0a;
  localparam logic MOVING_RST = 1'b1;

  typedef struct packed {
    logic en;
    logic moving;
    logic [9:0] win;
    logic [6:0] cnt;
  } wra_cfg_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } wra_sample_t;

  typedef struct packed {
    logic valid;
    logic is_final;
    logic [DATA_W-1:0] data;
  } wra_reading_t;

  typedef enum logic {WRA_ST_RUN, WRA_ST_WAIT} wra_state_e;
endpackage

/* File: wra_tb_top.sv */
// self-checking testbench for the windowed reading averager
`timescale 1ns/1ps
`default_nettype none
module wra_tb_top;
  import wra_pkg::*;
  logic clk, reset, wr_en, rd_en, start, busy, settling_indicator, settled_event;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data;
  logic [23:0] value;
  logic [3:0] lag;
  wra_sample_t conv;
  wra_reading_t reading;
  int failures = 0;
  int total_checks = 0;
  int seed = 66265;
  int stk[$];
  int base, cf, e_dat;
  bit setl, on, e_has, e_fin, e_set, scan;
  longint fsc;
  logic [31:0] cw[7];
  int ci[3] = '{0, 127, 50};
  int ce[3] = '{1, 100, 50};
  int wi[3] = '{1023, 0, 5};
  int we[3] = '{1000, 0, 5};

  wra_top dut_u (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .conv(conv), .reading(reading), .settling_indicator(settling_indicator),
    .settled_event(settled_event));
  wra_adc_model adc_u (.clk(clk), .reset(reset), .start(start), .value(value), .lag(lag), .conv(conv),
    .busy(busy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out();
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] cword(input int en, input int mov, input int win, input int cnt);
    return (cnt << CFG_CNT_LSB) | (win << CFG_WIN_LSB) | (mov << CFG_MOVING_BIT) | (en << CFG_EN_BIT);
  endfunction

  // reference filter: what one conversion should produce
  function automatic void ref_step(input int v);
    int band, cnt;
    longint s;
    logic [31:0] w;
    w = cw[cf];
    cnt = int'(w[CFG_CNT_LSB +: 7]);
    on = w[CFG_EN_BIT] && !(scan && w[CFG_MOVING_BIT]);
    band = (scan || w[CFG_WIN_LSB +: 10] == 10'h000) ? -1 : int'(fsc * longint'(w[CFG_WIN_LSB +: 10]) / WIN_DIV);
    e_has = 1'b1;
    e_dat = v;
    e_fin = 1'b0;
    if (on && stk.size() != 0 && band >= 0 && (v - base > band || base - v > band)) begin
      stk = '{v};
      base = v;
      setl = (cnt == 1);
      e_has = w[CFG_MOVING_BIT] && cnt > 1;
      if (!w[CFG_MOVING_BIT] && cnt == 1) stk.delete();
    end else if (on) begin
      if (stk.size() == 0) base = v;
      stk.push_back(v);
      if (w[CFG_MOVING_BIT] && stk.size() > cnt) void'(stk.pop_front());
      s = 0;
      foreach (stk[i]) s += stk[i];
      e_dat = int'(s / stk.size());
      e_fin = (stk.size() == cnt);
      e_has = w[CFG_MOVING_BIT] || e_fin;
      if (e_fin) setl = 1'b1;
      if (!w[CFG_MOVING_BIT] && e_fin) stk.delete();
    end
    e_set = on && !setl;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    stk.delete();
    setl = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  task automatic cfg(input int f, input logic [31:0] w);
    cw[f] = w;
    wr(ADDR_CFG_BASE + 8'(4 * f), w);
  endtask

  task automatic sel(input int f, input bit sc);
    wr(ADDR_CTRL, {28'h0, sc, 3'(f)});
    cf = f;
    scan = sc;
  endtask

  task automatic fs(input int v);
    wr(ADDR_FSCALE, 32'(v));
    fsc = v;
  endtask

  task automatic send(input int v);
    int n;
    logic [23:0] d;
    logic f;
    n = 0;
    ref_step(v);
    @(posedge clk);
    start <= 1'b1;
    value <= v[23:0];
    lag <= 4'($random(seed) & 15);
    @(posedge clk);
    start <= 1'b0;
    repeat (80) begin
      @(posedge clk);
      #1;
      if (reading.valid === 1'b1) begin
        n++;
        d = reading.data;
        f = reading.is_final;
      end
    end
    chk(n, e_has);
    if (e_has && n == 1) begin
      chk(d, e_dat[23:0]);
      if (on) chk(f, e_fin);
    end
    chk(settling_indicator, e_set);
    chk(settled_event, !e_set);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end

  initial begin
    reset = 1'b1;
    addr = 8'h00;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    start = 1'b0;
    value = 24'h000000;
    lag = 4'h0;
    foreach (cw[i]) cw[i] = 32'h000a002a;
    fsc = 1000000;
    cf = 0;
    scan = 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_CFG_BASE, 32'h000a002a);
    rd(ADDR_FSCALE, 32'h000f4240);
    rd(ADDR_STATUS, 32'h00000100);
    rd(8'h10, 32'h00000000);
    send(291);
    for (int i = 0; i < 3; i++) begin
      cfg(1, cword(0, 1, wi[i], ci[i]));
      rd(ADDR_CFG_BASE + 8'h04, cword(0, 1, we[i], ce[i]));
    end
    // moving, band of 10 counts around 500
    fs(1000);
    cfg(0, cword(1, 1, 100, 4));
    send(500);
    send(505);
    send(490);
    send(510);
    repeat (6) send(500 + $random(seed) % 11);
    send(511);
    cfg(0, cword(1, 1, 100, 1));
    send(200);
    send(205);
    send(300);
    send(300);
    cfg(0, cword(1, 0, 100, 3));
    repeat (6) send(500 + $random(seed) % 6);
    // per-function settings survive selection
    cfg(2, cword(1, 0, 0, 2));
    sel(2, 1'b0);
    rd(ADDR_CFG_BASE, cw[0]);
    send(10);
    send(21);
    sel(2, 1'b1);
    cfg(2, cword(1, 0, 100, 2));
    send(100);
    send(900);
    cfg(2, cword(1, 1, 100, 2));
    send(77);
    sel(6, 1'b0);
    fs(760);
    cfg(6, cword(1, 1, 1000, 2));
    send(100);
    send(176);
    send(253);
    rd(ADDR_CFG_BASE + 8'h08, cw[2]);
    rd(ADDR_STATUS, 32'h00010001);
    rd(ADDR_RESULT, 32'h000000fd);
    // second reset in mid-run: every setting falls back to its default
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk(reading, 26'h0);
    chk(settling_indicator, 1'b0);
    chk(settled_event, 1'b1);
    foreach (cw[i]) cw[i] = 32'h000a002a;
    fsc = 1000000;
    cf = 0;
    scan = 1'b0;
    // function code 7 does not exist and must be refused
    wr(ADDR_CTRL, 32'h00000007);
    rd(ADDR_CTRL, 32'h00000000);
    rd(ADDR_CFG_BASE + 8'h08, 32'h000a002a);
    send(-5);
    rd(ADDR_RESULT, 32'hfffffffb);
    close_out();
  end
endmodule
`default_nettype wire

/* File: wra_top.sv */
// windowed reading averager: per-function settings, averaging stack, window restart
// Overview of operation
// RULE_01: output is the average of a settable count of conversions, 1 to 100
// RULE_02: seven functions each keep their own filter settings, restored on selection
// RULE_03: only consecutive in-window conversions enter the averaging stack
// RULE_04: a full stack is averaged into the final filtered reading
// RULE_05: count 1 passes single conversions, still only those inside the window
// RULE_06: settling indicator and not-final mark while filling, cleared once settled
// RULE_07: out-of-window conversion restarts the filter with itself as initial value
// RULE_08: window is none or 0.01% to 10%
// RULE_09: voltage, current, resistance band is window percent of present range
// RULE_10: temperature band is window percent of the sensor's maximum reading
// RULE_11: moving mode is a FIFO; each new conversion evicts the oldest and re-averages
// RULE_12: repeating mode fills, averages, clears the stack, then refills
// RULE_13: scanning forces repeating mode so channels never mix
// RULE_14: a scan channel set to moving mode keeps its filter disabled
// RULE_15: status bit 8 sets when the filter has settled or is disabled
// RULE_16: settings apply at once when enabled, at next enable when disabled
// RULE_17: function or range change resets the filter and loads that stored setup
// RULE_18: window check compares each conversion with the run's initial conversion
// RULE_19: average is sum over count, sum wide enough for 100 conversions
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module wra_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire wra_pkg::wra_sample_t conv,
  output wra_pkg::wra_reading_t reading,
  output logic settling_indicator,
  output logic settled_event
);
  import wra_pkg::*;

  typedef struct packed {
    logic [2:0] func;
    logic scan;
    logic [23:0] fscale;
    wra_cfg_t [N_FUNC-1:0] cfg;
    wra_cfg_t act;
    logic [CNT_MAX-1:0][DATA_W-1:0] stack;
    logic [6:0] fill;
    logic [6:0] wp;
    logic signed [SUM_W-1:0] sum;
    logic [DATA_W-1:0] base_v;
    logic settled;
    wra_state_e st;
    logic pend_final;
    logic div_start;
    logic signed [SUM_W-1:0] div_dvd;
    logic [6:0] div_den;
    logic [31:0] rd_data;
    wra_reading_t reading;
    logic settling;
    logic settled_ev;
  } wra_top_st_t;

  wra_top_st_t s_q, s_d;
  wra_cfg_t sel, eff, wcfg;
  logic [23:0] band;
  logic div_busy, div_done;
  logic [23:0] div_q;
  logic restart, in_win, drop, win_restart;
  logic [DATA_W:0] diff, mag;

  function automatic logic signed [SUM_W-1:0] sx(input logic [DATA_W-1:0] v);
    return {{(SUM_W-DATA_W){v[DATA_W-1]}}, v};
  endfunction

  // band lags a window change by a cycle; the restart that follows skips the check anyway
  wra_band u_band (
    .clk(clk),
    .reset(reset),
    .fscale(s_q.fscale),
    .win(s_q.act.win),
    .band(band)
  );

  wra_avg_div u_div (
    .clk(clk),
    .reset(reset),
    .start(s_q.div_start),
    .dividend(s_q.div_dvd),
    .divisor(s_q.div_den),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_q)
  );

  always_comb begin
    s_d = s_q;
    s_d.div_start = 1'b0;
    s_d.reading.valid = 1'b0;
    s_d.rd_data = '0;
    restart = 1'b0;
    in_win = 1'b0;
    drop = 1'b0;
    win_restart = 1'b0;
    diff = '0;
    mag = '0;
    // decode a write; out-of-range count and window are clamped
    wcfg.en = wr_data[CFG_EN_BIT];
    wcfg.moving = wr_data[CFG_MOVING_BIT];
    wcfg.win = wr_data[CFG_WIN_LSB +: 10];
    wcfg.cnt = wr_data[CFG_CNT_LSB +: 7];
    if (wcfg.cnt < CNT_MIN_V) begin
      wcfg.cnt = CNT_MIN_V; // [RULE_01]
    end else if (wcfg.cnt > CNT_MAX_V) begin
      wcfg.cnt = CNT_MAX_V; // [RULE_01]
    end
    if (wcfg.win > WIN_MAX_V) begin
      wcfg.win = WIN_MAX_V; // [RULE_08]
    end
    if (wr_en) begin
      if (addr == ADDR_CTRL) begin
        if (wr_data[CTRL_FUNC_LSB +: 3] <= FUNC_LAST) begin
          s_d.func = wr_data[CTRL_FUNC_LSB +: 3];
        end
        s_d.scan = wr_data[CTRL_SCAN_BIT];
      end else if (addr == ADDR_FSCALE) begin
        s_d.fscale = wr_data[23:0];
      end else if ((addr & ADDR_CFG_MASK) == ADDR_CFG_BASE && addr[4:2] <= FUNC_LAST && addr[1:0] == 2'h0) begin
        s_d.cfg[addr[4:2]] = wcfg; // [RULE_02]
      end
    end
    // settings of the selected function, bent by scanning
    sel = s_d.cfg[s_d.func]; // [RULE_02]
    eff = sel;
    if (s_d.scan) begin
      eff.win = '0;
      eff.moving = 1'b0; // [RULE_13]
      eff.en = sel.en && !sel.moving; // [RULE_14]
    end
    if (s_d.func != s_q.func || s_d.fscale != s_q.fscale || s_d.scan != s_q.scan) begin
      restart = 1'b1; // [RULE_17]
    end
    // a disabled filter holds its old active copy until re-enabled
    if (eff.en && eff != s_q.act) begin
      restart = 1'b1;
      s_d.act = eff; // [RULE_16]
    end else if (!eff.en && s_q.act.en) begin
      restart = 1'b1;
      s_d.act.en = 1'b0; // [RULE_16]
    end
    if (restart) begin
      s_d.fill = '0;
      s_d.wp = '0;
      s_d.sum = '0;
      s_d.settled = 1'b0;
    end
    case (s_q.st)
      WRA_ST_RUN: begin
        if (conv.valid && !s_d.act.en) begin
          s_d.reading.valid = 1'b1;
          s_d.reading.is_final = 1'b1;
          s_d.reading.data = conv.data;
        end else if (conv.valid) begin
          diff = {conv.data[DATA_W-1], conv.data} - {s_d.base_v[DATA_W-1], s_d.base_v}; // [RULE_18]
          mag = diff[DATA_W] ? (DATA_W+1)'(-diff) : diff;
          in_win = (s_d.act.win == '0) || (s_d.fill == '0) || (mag <= {1'b0, band}); // [RULE_03]
          if (!in_win) begin
            win_restart = 1'b1;
            s_d.fill = '0; // [RULE_07]
            s_d.wp = '0;
            s_d.sum = '0;
            s_d.settled = 1'b0;
            drop = (s_d.act.cnt == CNT_MIN_V); // [RULE_05]
          end
          if (s_d.fill == '0) begin
            s_d.base_v = conv.data; // [RULE_07] [RULE_18]
          end
          if (s_d.fill == s_d.act.cnt) begin
            s_d.sum = s_d.sum - sx(s_d.stack[s_d.wp]) + sx(conv.data); // [RULE_11]
          end else begin
            s_d.sum = s_d.sum + sx(conv.data); // [RULE_19]
            s_d.fill = 7'(s_d.fill + 7'h01);
          end
          s_d.stack[s_d.wp] = conv.data; // [RULE_03]
          s_d.wp = (7'(s_d.wp + 7'h01) == s_d.act.cnt) ? 7'h00 : 7'(s_d.wp + 7'h01);
          if (s_d.fill == s_d.act.cnt) begin
            s_d.settled = 1'b1; // [RULE_06]
          end
          if (!drop && (s_d.act.moving || s_d.fill == s_d.act.cnt)) begin
            s_d.div_start = 1'b1; // [RULE_04]
            s_d.div_dvd = s_d.sum;
            s_d.div_den = s_d.act.moving ? s_d.fill : s_d.act.cnt;
            s_d.pend_final = (s_d.fill == s_d.act.cnt); // [RULE_06]
            s_d.st = WRA_ST_WAIT;
          end
          if (!s_d.act.moving && s_d.fill == s_d.act.cnt) begin
            s_d.fill = '0; // [RULE_12]
            s_d.wp = '0;
            s_d.sum = '0;
          end
        end
      end
      WRA_ST_WAIT: begin
        // conversions landing during the divide are not taken
        if (div_done) begin
          s_d.reading.valid = 1'b1;
          s_d.reading.is_final = s_q.pend_final;
          s_d.reading.data = div_q;
          s_d.st = WRA_ST_RUN;
        end
      end
      default: begin
        s_d.st = WRA_ST_RUN;
      end
    endcase
    s_d.settling = s_d.act.en && !s_d.settled; // [RULE_06]
    s_d.settled_ev = !s_d.act.en || s_d.settled; // [RULE_15]
    if (rd_en) begin
      if (addr == ADDR_CTRL) begin
        s_d.rd_data[CTRL_FUNC_LSB +: 3] = s_q.func;
        s_d.rd_data[CTRL_SCAN_BIT] = s_q.scan;
      end else if (addr == ADDR_FSCALE) begin
        s_d.rd_data[23:0] = s_q.fscale;
      end else if (addr == ADDR_STATUS) begin
        s_d.rd_data[STATUS_SETTLING_BIT] = s_q.settling;
        s_d.rd_data[STATUS_SETTLED_BIT] = s_q.settled_ev; // [RULE_15]
        s_d.rd_data[STATUS_FILL_LSB +: 7] = s_q.fill;
      end else if (addr == ADDR_RESULT) begin
        s_d.rd_data = sx(s_q.reading.data);
      end else if ((addr & ADDR_CFG_MASK) == ADDR_CFG_BASE && addr[4:2] <= FUNC_LAST && addr[1:0] == 2'h0) begin
        s_d.rd_data[CFG_EN_BIT] = s_q.cfg[addr[4:2]].en;
        s_d.rd_data[CFG_MOVING_BIT] = s_q.cfg[addr[4:2]].moving;
        s_d.rd_data[CFG_WIN_LSB +: 10] = s_q.cfg[addr[4:2]].win;
        s_d.rd_data[CFG_CNT_LSB +: 7] = s_q.cfg[addr[4:2]].cnt;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.fscale <= FSCALE_RST;
      s_q.cfg <= {N_FUNC{1'b0, MOVING_RST, WIN_RST, CNT_RST}};
      s_q.act <= {1'b0, MOVING_RST, WIN_RST, CNT_RST};
      s_q.settled_ev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rd_data;
  assign reading = s_q.reading;
  assign settling_indicator = s_q.settling;
  assign settled_event = s_q.settled_ev;

  chk_count_range: assert property (@(posedge clk) disable iff (reset) // [RULE_01]
    s_q.act.cnt >= CNT_MIN_V && s_q.act.cnt <= CNT_MAX_V)
    else $error("active count outside 1 to 100");
  chk_window_range: assert property (@(posedge clk) disable iff (reset) // [RULE_08]
    s_q.act.win <= WIN_MAX_V)
    else $error("active window above 10 percent");
  chk_fill_bound: assert property (@(posedge clk) disable iff (reset) // [RULE_04]
    s_q.act.en |-> s_q.fill <= s_q.act.cnt)
    else $error("stack fill above count");
  chk_settle_excl: assert property (@(posedge clk) disable iff (reset) // [RULE_06]
    !(settling_indicator && settled_event))
    else $error("settling and settled both shown");
  chk_disabled_event: assert property (@(posedge clk) disable iff (reset) // [RULE_15]
    !s_q.act.en |-> settled_event && !settling_indicator)
    else $error("settled event low while filter disabled");
  chk_scan_repeat: assert property (@(posedge clk) disable iff (reset) // [RULE_13]
    (s_q.scan && s_q.act.en) |-> !s_q.act.moving)
    else $error("moving mode active while scanning");
  chk_window_restart: assert property (@(posedge clk) disable iff (reset) // [RULE_07]
    (win_restart && s_d.act.cnt > CNT_MIN_V) |=> s_q.fill == 7'h01 && !settled_event)
    else $error("window restart did not reload stack");
  chk_pass_through: assert property (@(posedge clk) disable iff (reset) // [RULE_16]
    (s_q.st == WRA_ST_RUN && conv.valid && !s_d.act.en) |=> reading.valid && reading.data == $past(conv.data))
    else $error("disabled filter did not pass conversion");
  // sequencing around one conversion; the divide keeps the next one out meanwhile
  chk_drop_silent: assert property (@(posedge clk) disable iff (reset) // [RULE_05]
    (win_restart && s_d.act.cnt == CNT_MIN_V) |=> !reading.valid && s_q.st == WRA_ST_RUN)
    else $error("out-of-window conversion at count 1 was output");
  chk_fill_step: assert property (@(posedge clk) disable iff (reset) // [RULE_03]
    (s_q.st == WRA_ST_RUN && conv.valid && s_q.act.en && s_q.act.moving && !restart && !win_restart &&
      s_q.fill < s_q.act.cnt) |=> s_q.fill == $past(s_q.fill) + 7'h01)
    else $error("in-window conversion did not enter the stack");
  chk_moving_full: assert property (@(posedge clk) disable iff (reset) // [RULE_11]
    (s_q.st == WRA_ST_RUN && conv.valid && s_q.act.en && s_q.act.moving && !restart && !win_restart &&
      s_q.fill == s_q.act.cnt) |=> s_q.fill == s_q.act.cnt && s_q.st == WRA_ST_WAIT)
    else $error("full moving stack did not evict and re-average");
  chk_repeat_clear: assert property (@(posedge clk) disable iff (reset) // [RULE_12]
    (s_q.st == WRA_ST_RUN && s_d.div_start && !s_d.act.moving) |=> s_q.fill == 7'h00 && s_q.st == WRA_ST_WAIT)
    else $error("repeating stack not cleared after its average");
  chk_reading_due: assert property (@(posedge clk) disable iff (reset) // [RULE_04]
    (s_q.st == WRA_ST_RUN && s_d.div_start) |-> ##35 reading.valid)
    else $error("average not delivered 35 cycles after the conversion");
  chk_moving_settling: assert property (@(posedge clk) disable iff (reset) // [RULE_06]
    (s_q.act.en && s_q.act.moving && s_q.fill < s_q.act.cnt) |-> settling_indicator)
    else $error("moving stack still filling but settling indicator low");
  chk_func_restart: assert property (@(posedge clk) disable iff (reset) // [RULE_17]
    (s_d.func != s_q.func && !conv.valid) |=> s_q.fill == 7'h00)
    else $error("function change did not empty the stack");
  chk_scan_window: assert property (@(posedge clk) disable iff (reset) // [RULE_13]
    (s_q.scan && s_q.act.en) |-> s_q.act.win == 10'h000)
    else $error("window check left active while scanning");
endmodule
`default_nettype wire
